//--- two_wire_map.vh
// Purpose: constants for the two-wire master transmitter
// Assumes: registers reached by a 2-bit register index
// Notes: status codes are given with the three low bits at zero
`ifndef TWO_WIRE_MAP_VH
`define TWO_WIRE_MAP_VH

// Register indices
`define OFS_CONTROL 2'h0
`define OFS_STATUS 2'h1
`define OFS_DATA 2'h2
`define OFS_MODE 2'h3

// Control register bit positions
`define CTL_DONE 7
`define CTL_ACK_EN 6
`define CTL_START 5
`define CTL_STOP 4
`define CTL_WCOL 3
`define CTL_ENABLE 2
`define CTL_IRQ_EN 0

// Reset values
`define RST_STATUS 8'hf8
`define RST_DATA 8'hff
`define RST_ALLOW 4'hf

// Status codes
`define CODE_START 8'h08
`define CODE_REP_START 8'h10
`define CODE_AW_ACK 8'h18
`define CODE_AW_NACK 8'h20
`define CODE_DATA_ACK 8'h28
`define CODE_DATA_NACK 8'h30
`define CODE_ARB_LOST 8'h38
`define CODE_AR_ACK 8'h40
`define CODE_AR_NACK 8'h48
`define CODE_IDLE 8'hf8

// Mode encodings of the current-mode field
`define MODE_NONE 2'h0
`define MODE_XMIT 2'h1
`define MODE_RECV 2'h2

// Bus timing: one bit time, split into four quarter phases
`define CLK_PERIOD_NS 20
`define BIT_TIME_NS 10000
`define QUARTER_CYCLES ((`BIT_TIME_NS / 4 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- two_wire_master_transmitter.v
// Purpose: two-wire bus master transmitter with control, status, data and mode registers
// Assumes: open-drain lines, enable high pulls the line low; pins are asynchronous
// Notes: bit-rate generator, master receiver data phase and slave modes are not built
//
// Summary of operation
// - Four modes; software picks which are allowed
// - Transfer suspended while done flag set
// - Status code per event, prescaler bits zero
// - Start request launches START once bus free
// - After START set flag, status 0x08
// - Address direction bit selects transmit or receive
// - Address-write result 0x18, 0x20 or 0x38
// - Data write with flag low: discard, collision
// - Data byte result 0x28, 0x30 or 0x38
// - Plain flag clear sends the loaded byte
// - Clear with start only gives repeated START
// - Clear with stop sends STOP, clears stop
// - Start and stop: STOP then START
// - Repeated START reports 0x10, mode follows address
// - Arbitration loss: 0x38, release or restart
// - Read high, write low; ACK low
// - Eight data bits then one acknowledge bit
// - Writing one clears the done flag
//
// Decided for this implementation: the address map and strobed register access.
`include "two_wire_map.vh"

module two_wire_master_transmitter #(
  parameter [15:0] QUARTER = `QUARTER_CYCLES
) (
  input wire clock,
  input wire rst,
  input wire [1:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_START = 3'h1;
  localparam [2:0] S_BYTE = 3'h2;
  localparam [2:0] S_STOP = 3'h3;
  localparam [2:0] S_HOLD = 3'h4;

  reg scl_meta_reg;
  reg scl_sync_reg;
  reg sda_meta_reg;
  reg sda_sync_reg;
  reg sda_prev_reg;
  reg busy_reg;

  reg flag_reg;
  reg ack_en_reg;
  reg start_req_reg;
  reg stop_req_reg;
  reg wcol_reg;
  reg enable_reg;
  reg irq_en_reg;
  reg [7:0] status_reg;
  reg [7:0] data_reg;
  reg [3:0] allow_reg;
  reg [1:0] mode_reg;

  reg [2:0] state_reg;
  reg [1:0] phase_reg;
  reg [15:0] cnt_reg;
  reg [3:0] bit_reg;
  reg [7:0] shift_reg;
  reg addr_phase_reg;
  reg rep_reg;

  wire tick;
  wire bus_free;
  wire ctl_wr;
  wire post_start;
  wire post_read;

  assign tick = (cnt_reg == 16'h0000);
  assign bus_free = !busy_reg && scl_sync_reg && sda_sync_reg;
  assign ctl_wr = wr_en && (addr == `OFS_CONTROL);
  assign post_start = (status_reg == `CODE_START) || (status_reg == `CODE_REP_START);
  assign post_read = (status_reg == `CODE_AR_ACK) || (status_reg == `CODE_AR_NACK);

  // Two-flop synchronisers on both bus lines; the meta flops feed nothing else
  always @(posedge clock) begin
    if (rst) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // Bus monitor: START seen makes the bus busy, STOP frees it
  // Catches other masters too, so a pending start waits for their STOP
  always @(posedge clock) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else if (scl_sync_reg && sda_prev_reg && !sda_sync_reg) begin
      busy_reg <= 1'b1;
    end else if (scl_sync_reg && !sda_prev_reg && sda_sync_reg) begin
      busy_reg <= 1'b0;
    end
  end

  // Read port: data valid in the cycle after the strobe only
  always @(posedge clock) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `OFS_CONTROL: rdata <= {flag_reg, ack_en_reg, start_req_reg, stop_req_reg,
                                wcol_reg, enable_reg, 1'b0, irq_en_reg};
        `OFS_STATUS: rdata <= {status_reg[7:3], 3'b000};
        `OFS_DATA: rdata <= data_reg;
        `OFS_MODE: rdata <= {mode_reg, 2'b00, allow_reg};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Register writes and the bus engine share one process so that
  // hardware updates placed later override a same-cycle software write
  always @(posedge clock) begin
    if (rst) begin
      flag_reg <= 1'b0;
      ack_en_reg <= 1'b0;
      start_req_reg <= 1'b0;
      stop_req_reg <= 1'b0;
      wcol_reg <= 1'b0;
      enable_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      status_reg <= `RST_STATUS;
      data_reg <= `RST_DATA;
      allow_reg <= `RST_ALLOW;
      mode_reg <= `MODE_NONE;
      state_reg <= S_IDLE;
      phase_reg <= 2'h0;
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_phase_reg <= 1'b0;
      rep_reg <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      // Lines are open drain: output level fixed low, enable pulls
      scl_out <= 1'b0;
      sda_out <= 1'b0;

      // Control register write
      if (ctl_wr) begin
        if (wdata[`CTL_DONE]) begin
          flag_reg <= 1'b0;
        end
        ack_en_reg <= wdata[`CTL_ACK_EN];
        start_req_reg <= wdata[`CTL_START];
        stop_req_reg <= wdata[`CTL_STOP];
        enable_reg <= wdata[`CTL_ENABLE];
        irq_en_reg <= wdata[`CTL_IRQ_EN];
      end

      if (wr_en && (addr == `OFS_DATA)) begin
        if (flag_reg) begin
          data_reg <= wdata;
          wcol_reg <= 1'b0;
        end else begin
          wcol_reg <= 1'b1;
        end
      end

      if (wr_en && (addr == `OFS_MODE)) begin
        allow_reg <= wdata[3:0];
      end

      // Quarter-bit timer, reloaded on each tick
      if (tick) begin
        cnt_reg <= QUARTER - 16'h0001;
      end else begin
        cnt_reg <= cnt_reg - 16'h0001;
      end

      if (!enable_reg) begin
        state_reg <= S_IDLE;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        mode_reg <= `MODE_NONE;
        rep_reg <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            if (start_req_reg && !flag_reg && bus_free && (allow_reg[0] || allow_reg[1])) begin
              state_reg <= S_START;
              phase_reg <= 2'h0;
              cnt_reg <= QUARTER - 16'h0001;
            end
          end

          // START or repeated START: release both lines, then SDA low under SCL high
          S_START: begin
            if (tick) begin
              case (phase_reg)
                2'h0: begin
                  sda_oe <= 1'b0;
                  phase_reg <= 2'h1;
                end
                2'h1: begin
                  scl_oe <= 1'b0;
                  phase_reg <= 2'h2;
                end
                2'h2: begin
                  // Waits out a slave that stretches the clock
                  if (scl_sync_reg) begin
                    sda_oe <= 1'b1;
                    phase_reg <= 2'h3;
                  end
                end
                default: begin
                  scl_oe <= 1'b1;
                  flag_reg <= 1'b1;
                  status_reg <= rep_reg ? `CODE_REP_START : `CODE_START;
                  rep_reg <= 1'b1;
                  state_reg <= S_HOLD;
                end
              endcase
            end
          end

          // One bit per four quarters; bit index 8 is the acknowledge slot
          S_BYTE: begin
            if (tick) begin
              case (phase_reg)
                2'h0: begin
                  sda_oe <= (bit_reg == 4'h8) ? 1'b0 : !shift_reg[7];
                  phase_reg <= 2'h1;
                end
                2'h1: begin
                  scl_oe <= 1'b0;
                  phase_reg <= 2'h2;
                end
                2'h2: begin
                  if (scl_sync_reg) begin
                    if ((bit_reg != 4'h8) && shift_reg[7] && !sda_sync_reg) begin
                      scl_oe <= 1'b0;
                      sda_oe <= 1'b0;
                      status_reg <= `CODE_ARB_LOST;
                      flag_reg <= 1'b1;
                      mode_reg <= `MODE_NONE;
                      rep_reg <= 1'b0;
                      state_reg <= S_HOLD;
                    end else begin
                      phase_reg <= 2'h3;
                    end
                  end
                end
                default: begin
                  scl_oe <= 1'b1;
                  phase_reg <= 2'h0;
                  if (bit_reg == 4'h8) begin
                    flag_reg <= 1'b1;
                    state_reg <= S_HOLD;
                    if (!addr_phase_reg) begin
                      status_reg <= sda_sync_reg ? `CODE_DATA_NACK : `CODE_DATA_ACK;
                    end else if (shift_reg[7]) begin
                      status_reg <= sda_sync_reg ? `CODE_AR_NACK : `CODE_AR_ACK;
                      mode_reg <= `MODE_RECV;
                    end else begin
                      status_reg <= sda_sync_reg ? `CODE_AW_NACK : `CODE_AW_ACK;
                      mode_reg <= `MODE_XMIT;
                    end
                  end else begin
                    // Direction bit ends up in bit 7 at the ack slot
                    shift_reg <= {shift_reg[6:0], shift_reg[0]};
                    bit_reg <= bit_reg + 4'h1;
                  end
                end
              endcase
            end
          end

          // STOP: SDA low under SCL low, release SCL, then SDA
          S_STOP: begin
            if (tick) begin
              case (phase_reg)
                2'h0: begin
                  sda_oe <= 1'b1;
                  phase_reg <= 2'h1;
                end
                2'h1: begin
                  scl_oe <= 1'b0;
                  phase_reg <= 2'h2;
                end
                2'h2: begin
                  if (scl_sync_reg) begin
                    sda_oe <= 1'b0;
                    phase_reg <= 2'h3;
                  end
                end
                default: begin
                  stop_req_reg <= 1'b0;
                  rep_reg <= 1'b0;
                  mode_reg <= `MODE_NONE;
                  state_reg <= S_IDLE;
                end
              endcase
            end
          end

          S_HOLD: begin
            if (!flag_reg) begin
              phase_reg <= 2'h0;
              cnt_reg <= QUARTER - 16'h0001;
              if (status_reg == `CODE_ARB_LOST) begin
                state_reg <= S_IDLE;
              end else if (stop_req_reg) begin
                state_reg <= S_STOP;
              end else if (start_req_reg && !post_start) begin
                state_reg <= S_START;
              end else if (post_read) begin
                // No receive path: a plain clear ends the transfer
                state_reg <= S_STOP;
              end else begin
                shift_reg <= data_reg;
                bit_reg <= 4'h0;
                addr_phase_reg <= post_start;
                state_reg <= S_BYTE;
              end
            end
          end

          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // two_wire_master_transmitter

//--- two_wire_master_transmitter_properties.sv
// Purpose: port-level checks for the two-wire master transmitter
// Assumes: QUARTER of 4 cycles in the bench; both lines pulled up
// Notes: done flag is internal, so hold rules are judged by SCL timing
`include "two_wire_map.vh"
module two_wire_master_transmitter_properties #(
  parameter [15:0] QUARTER = 16'h0004
) (
  input wire clock,
  input wire rst,
  input wire [1:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rdata,
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_rdata_quiet; !$past(rd_en) |-> rdata == 8'h00; endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("rdata set without read");
  property p_status_low; $past(rd_en) && $past(addr) == `OFS_STATUS |-> rdata[2:0] == 3'h0;
  endproperty
  a_status_low: assert property (p_status_low) else $error("status low bits set");
  property p_ctl_unused; $past(rd_en) && $past(addr) == `OFS_CONTROL |-> !rdata[1]; endproperty
  a_ctl_unused: assert property (p_ctl_unused) else $error("control bit 1 set");
  property p_outs_zero; scl_out == 1'b0 && sda_out == 1'b0; endproperty
  a_outs_zero: assert property (p_outs_zero) else $error("line driven high");
  // High phase is two quarters at least, longer when stretched
  property p_scl_high; $fell(scl_oe) |=> (!scl_oe) [*7]; endproperty
  a_scl_high: assert property (p_scl_high) else $error("scl high too short");
  property p_scl_low; $rose(scl_oe) |=> scl_oe [*7]; endproperty
  a_scl_low: assert property (p_scl_low) else $error("scl low too short");
  // START edge is followed by SCL pulled low within six cycles
  property p_start_hold; $rose(sda_oe) && !scl_oe |-> ##[1:6] scl_oe; endproperty
  a_start_hold: assert property (p_start_hold) else $error("scl not held after start");
  property p_stop_free; $fell(sda_oe) && !scl_oe |=> (!sda_oe && !scl_oe) [*3]; endproperty
  a_stop_free: assert property (p_stop_free) else $error("bus not free after stop");
  property p_reset_idle; $fell(rst) |-> rdata == 8'h00 && !scl_oe && !sda_oe; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("lines busy after reset");
endmodule // two_wire_master_transmitter_properties

bind two_wire_master_transmitter two_wire_master_transmitter_properties #(.QUARTER(QUARTER)) chk_i (
  .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata(rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe));

//--- two_wire_slave_model.sv
// Purpose: slave receiver and rival master on the two-wire bus
// Assumes: lines sampled on the system clock
// Notes: a stolen bit is held, then released while SCL is high, which forms a STOP
module two_wire_slave_model (
  input wire clock,
  input wire scl,
  input wire sda,
  input wire nack,
  input wire [3:0] steal_bit,
  output logic sda_pull,
  output logic [7:0] last_byte,
  output logic [7:0] stop_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_d, sda_d;
  logic [3:0] bit_n;
  logic [7:0] shift_reg, hi_cnt;
  initial begin
    {sda_pull, last_byte, stop_cnt, bit_n, shift_reg, hi_cnt} = '0;
    {scl_d, sda_d} = 2'b11;
  end
  // Frame tracking; edges of SDA with SCL high are START or STOP
  always @(posedge clock) begin
    scl_d <= scl;
    sda_d <= sda;
    // Unknown line before reset must not poison the counter
    hi_cnt <= (scl === 1'b1) ? hi_cnt + 8'h01 : 8'h00;
    if (scl && scl_d && sda_d && !sda) begin
      bit_n <= 4'h0;
    end else if (scl && scl_d && !sda_d && sda) begin
      stop_cnt <= stop_cnt + 8'h01;
    end else if (scl && !scl_d) begin
      shift_reg <= {shift_reg[6:0], sda};
      if (bit_n == 4'h7) last_byte <= {shift_reg[6:0], sda};
      bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
    // ack is low, nack left high
    end else if (!scl && scl_d) begin
      sda_pull <= (bit_n == 4'h8 && !nack) || bit_n == steal_bit;
    end else if (hi_cnt == 8'h28) begin
      sda_pull <= 1'b0;
    end
  end
endmodule // two_wire_slave_model

//--- two_wire_master_transmitter_test.sv
// Purpose: register-level test of the two-wire master transmitter
// Assumes: QUARTER of 4 cycles; open-drain lines with pull-ups
// Notes: status is masked with 0xf8 before it is compared in step; the reset read compares it unmasked
`include "two_wire_map.vh"
module two_wire_master_transmitter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, wr_en = 0, rd_en = 0, nack = 0;
  logic [1:0] addr = 0;
  logic [7:0] wdata = 0, rdata, last_byte, stop_cnt, n, v;
  logic [3:0] steal_bit = 4'hf;
  wire scl_out, scl_oe, sda_out, sda_oe, sda_pull;
  wire scl_w = !scl_oe;
  wire sda_w = !(sda_oe || sda_pull);
  int num_errors = 0, n_tests = 0, cyc = 0;
  logic [7:0] bytes [3] = '{8'h5a, 8'h81, 8'h3c};
  logic [7:0] codes [3] = '{`CODE_DATA_ACK, `CODE_DATA_NACK, `CODE_DATA_ACK};
  always #10 clock = ~clock;
  two_wire_master_transmitter #(.QUARTER(16'h0004)) uut (.clock(clock), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  two_wire_slave_model far_end (.clock(clock), .scl(scl_w), .sda(sda_w), .nack(nack),
    .steal_bit(steal_bit), .sda_pull(sda_pull), .last_byte(last_byte), .stop_cnt(stop_cnt));
  task automatic report_and_stop;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge clock); wr_en <= 1'b0;
    @(posedge clock);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdv(input logic [1:0] a, output logic [7:0] d);
    addr <= a; rd_en <= 1'b1;
    @(posedge clock); rd_en <= 1'b0;
    #1 d = rdata;
    @(posedge clock);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    rdv(a, d); chk(nm, d, e);
  endtask
  // Polls control; bounded so a stuck transfer shows as a mismatch
  task automatic wait_ctl(input logic [7:0] m, input logic [7:0] e, input string nm);
    logic [7:0] d;
    for (int i = 0; i < 400; i++) begin
      rdv(`OFS_CONTROL, d);
      if ((d & m) === e) break;
    end
    chk(nm, d & m, e);
  endtask
  task automatic step(input logic [7:0] c, input logic [7:0] st);
    logic [7:0] d;
    wr(`OFS_CONTROL, c); wait_ctl(8'h80, 8'h80, "flag");
    rdv(`OFS_STATUS, d);
    chk("status", d & 8'hf8, st);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      report_and_stop;
    end
  end
  // every control write keeps enable set
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(0, 8'h00, "ctl reset");
    rd(1, `RST_STATUS, "status reset");
    rd(3, 8'h0f, "mode reset");
    wr(2, 8'h12); rd(2, `RST_DATA, "data discarded");
    rd(0, 8'h08, "collision set");
    // No master mode allowed: the start request has to wait
    wr(3, 8'h0c); wr(0, 8'h65); repeat (40) @(posedge clock);
    rd(0, 8'h6d, "start refused");
    chk("bus idle", {6'h0, scl_oe, sda_oe}, 8'h00);
    wr(3, 8'h0f); step(8'ha4, `CODE_START);
    wr(2, 8'ha6); rd(0, 8'ha4, "collision cleared");
    wr(0, 8'h24); repeat (20) @(posedge clock); rd(0, 8'ha4, "flag kept");
    chk("scl held", {7'h0, scl_oe}, 8'h01);
    step(8'h84, `CODE_AW_ACK);
    chk("address byte", last_byte, 8'ha6);
    rd(3, 8'h4f, "mode transmit");
    for (int i = 0; i < 3; i++) begin
      wr(2, bytes[i]); nack <= (i == 1);
      step(8'h84, codes[i]);
      chk("data byte", last_byte, bytes[i]);
    end
    nack <= 1'b0;
    step(8'ha4, `CODE_REP_START);
    wr(2, 8'ha7); step(8'h84, `CODE_AR_ACK);
    rd(3, 8'h8f, "mode receive");
    n = stop_cnt; step(8'hb4, `CODE_START);
    chk("stop count", stop_cnt, n + 8'h01);
    rd(0, 8'ha4, "stop bit cleared");
    wr(2, 8'ha6); nack <= 1'b1; step(8'h84, `CODE_AW_NACK);
    nack <= 1'b0; wr(0, 8'h94); wait_ctl(8'h10, 8'h00, "stop done");
    chk("stop count", stop_cnt, n + 8'h02);
    step(8'ha4, `CODE_START);
    // Rival pulls before the third address bit, which is sent high
    wr(2, 8'ha6); steal_bit <= 4'h2; step(8'h84, `CODE_ARB_LOST);
    chk("released", {6'h0, scl_oe, sda_oe}, 8'h00);
    steal_bit <= 4'hf; step(8'ha4, `CODE_START);
    wr(0, 8'h94); wait_ctl(8'h10, 8'h00, "final stop");
    report_and_stop;
  end
endmodule // two_wire_master_transmitter_test
